/* hdl/pwm_write_sync_status.sv */
// timer register writes over apb and their sync status toward the pwm side
`timescale 1ns/100ps
`default_nettype none
module pwm_write_sync_status (
   // clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pwm_sync_pkg::APB_ADDR_W-1:0] paddr,
   input wire logic [pwm_sync_pkg::DATA_W-1:0] pwdata,
   output logic [pwm_sync_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // pwm side: load slot strobe and transferred value
   input wire logic pwmTick,
   output logic loadStrobe,
   output logic [1:0] loadTimer,
   output logic [1:0] loadKind,
   output logic [pwm_sync_pkg::DATA_W-1:0] loadData
);
   import pwm_sync_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_LOAD} xfer_e;

   reg_store_if st ();

   logic access, hitTimer, hitStatus, aligned, busWrite;
   logic [IDX_W-1:0] busIdx;
   logic [NUM_REGS-1:0] pendQ, pendD;
   logic [DATA_W-1:0] statusWord;
   xfer_e stateQ, stateD;
   logic [IDX_W-1:0] selIdxQ, selIdxD;
   logic rewriteQ, rewriteD;
   logic doClear;

   timer_reg_store #(.DEPTH(NUM_REGS)) timer_reg_store_inst (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .st(st)
   );

   // address decode; every access answers without wait states
   assign access = psel && penable;
   assign aligned = (paddr[IDX_LSB-1:0] == 2'h0);
   assign hitTimer = aligned && paddr <= OFS_TIMER_LAST && paddr >= OFS_TIMER_FIRST;
   assign hitStatus = (paddr == OFS_SYNC_FLAGS);
   assign busIdx = paddr[IDX_LSB+IDX_W-1:IDX_LSB];
   assign busWrite = access && pwrite && hitTimer;
   assign pready = 1'b1;
   assign pslverr = access && !hitTimer && !hitStatus;

   // store access; duty writes keep only the count bits
   assign st.wrEn = busWrite;
   assign st.wrIdx = busIdx;
   assign st.wrData = pwdata & ((busIdx[1:0] == KIND_DUTY) ? DUTY_MASK : FULL_MASK);
   assign st.busIdx = busIdx;
   assign st.xferIdx = selIdxQ;

   // status word: flag of register t*4+k sits at bit t*8+k, the rest zero
   generate
      for (genvar t = 0; t < NUM_TIMERS; t++) begin : g_sts
         assign statusWord[t*STS_TIMER_STRIDE +: KINDS_PER_TIMER] =
            pendQ[t*KINDS_PER_TIMER +: KINDS_PER_TIMER];
         assign statusWord[t*STS_TIMER_STRIDE+KINDS_PER_TIMER +: KINDS_PER_TIMER] = 4'h0;
      end
   endgenerate

   // read data: store word is registered from the setup cycle
   always_comb begin
      prdata = RDATA_ZERO;
      if (access && !pwrite && hitTimer) begin
         prdata = st.busData;
      end else if (access && !pwrite && hitStatus) begin
         prdata = statusWord;
      end
   end

   // transfer engine: on a pwm tick move the lowest pending register across
   always_comb begin
      stateD = stateQ;
      selIdxD = selIdxQ;
      rewriteD = rewriteQ;
      doClear = 1'b0;
      case (stateQ)
         ST_IDLE: begin
            rewriteD = 1'b0;
            if (pwmTick && |pendQ) begin
               for (int i = NUM_REGS - 1; i >= 0; i--) begin
                  if (pendQ[i]) begin
                     selIdxD = IDX_W'(i);
                  end
               end
               stateD = ST_READ;
            end
         end
         ST_READ: begin
            // a write now is not in the word being read out
            rewriteD = busWrite && busIdx == selIdxQ;
            stateD = ST_LOAD;
         end
         ST_LOAD: begin
            doClear = !rewriteQ;
            stateD = ST_IDLE;
         end
         default: begin
            stateD = ST_IDLE;
         end
      endcase
   end

   // pending flags: clear on transfer, a write in the same cycle wins
   always_comb begin
      pendD = pendQ;
      if (doClear) begin
         pendD[selIdxQ] = 1'b0;
      end
      if (busWrite) begin
         pendD[busIdx] = 1'b1;
      end
   end

   // state registers
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pendQ <= PEND_RESET;
         stateQ <= ST_IDLE;
         selIdxQ <= '0;
         rewriteQ <= 1'b0;
      end else begin
         pendQ <= pendD;
         stateQ <= stateD;
         selIdxQ <= selIdxD;
         rewriteQ <= rewriteD;
      end
   end

   // pwm side outputs; data straight from the store's output register
   assign loadStrobe = (stateQ == ST_LOAD);
   assign loadTimer = selIdxQ[IDX_W-1:2];
   assign loadKind = selIdxQ[1:0];
   assign loadData = st.xferData;

   // checks
   logic stsRead;
   logic [NUM_REGS-1:0] selOneHot;
   assign stsRead = access && !pwrite && hitStatus;
   // one-hot of the register picked for transfer
   assign selOneHot = {{(NUM_REGS-1){1'b0}}, 1'b1} << selIdxQ;

   sequence s_tick_start;
      stateQ == ST_IDLE && pwmTick && |pendQ;
   endsequence
   sequence s_load_slot;
      stateQ == ST_READ ##1 loadStrobe;
   endsequence

   property p_t0_map;
      @(posedge ref_clk) disable iff (!arst_n)
      stsRead |-> prdata[3:0] == {pendQ[KIND_DUTY], pendQ[KIND_PERIOD],
         pendQ[KIND_PRESCALE], pendQ[KIND_CTRL]};
   endproperty
   a_t0_map: assert property (p_t0_map) else $error("timer 0 flags misplaced");

   property p_t1_map;
      @(posedge ref_clk) disable iff (!arst_n)
      stsRead |-> prdata[11:8] == pendQ[7:4];
   endproperty
   a_t1_map: assert property (p_t1_map) else $error("timer 1 flags misplaced");

   property p_t2_map;
      @(posedge ref_clk) disable iff (!arst_n)
      stsRead |-> prdata[19:16] == pendQ[11:8];
   endproperty
   a_t2_map: assert property (p_t2_map) else $error("timer 2 flags misplaced");

   property p_t3_map;
      @(posedge ref_clk) disable iff (!arst_n)
      stsRead |-> prdata[27:24] == pendQ[15:12];
   endproperty
   a_t3_map: assert property (p_t3_map) else $error("timer 3 flags misplaced");

   property p_reserved_zero;
      @(posedge ref_clk) disable iff (!arst_n)
      stsRead |-> (prdata & ~STS_USED_MASK) == RDATA_ZERO;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

   property p_set_on_write;
      @(posedge ref_clk) disable iff (!arst_n)
      busWrite |=> pendQ[$past(busIdx)] ##1 (pendQ[$past(busIdx, 2)] || $past(loadStrobe));
   endproperty
   a_set_on_write: assert property (p_set_on_write) else $error("flag not set by write");

   property p_fall_only_on_load;
      @(posedge ref_clk) disable iff (!arst_n)
      (|($past(pendQ) & ~pendQ)) |->
         $past(loadStrobe) && (($past(pendQ) & ~pendQ) == $past(selOneHot));
   endproperty
   a_fall_only_on_load: assert property (p_fall_only_on_load) else $error("flag fell without load");

   property p_clear_after_load;
      @(posedge ref_clk) disable iff (!arst_n)
      (loadStrobe && !rewriteQ && !(busWrite && busIdx == selIdxQ)) |=> !pendQ[$past(selIdxQ)];
   endproperty
   a_clear_after_load: assert property (p_clear_after_load) else $error("flag not cleared");

   property p_load_timing;
      @(posedge ref_clk) disable iff (!arst_n)
      s_tick_start |=> s_load_slot;
   endproperty
   a_load_timing: assert property (p_load_timing) else $error("load not two cycles after tick");

   property p_duty_width;
      @(posedge ref_clk) disable iff (!arst_n)
      (loadStrobe && loadKind == KIND_DUTY) |-> (loadData & ~DUTY_MASK) == RDATA_ZERO;
   endproperty
   a_duty_width: assert property (p_duty_width) else $error("duty wider than 12 bits");
endmodule
`default_nettype wire

/* inc/pwm_sync_pkg.sv */
// constants shared by the timer register store and its sync status logic
package pwm_sync_pkg;
   localparam int APB_ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int NUM_TIMERS = 4;
   localparam int KINDS_PER_TIMER = 4;
   localparam int NUM_REGS = NUM_TIMERS * KINDS_PER_TIMER;
   localparam int IDX_W = 4;
   // register byte offsets: timer n block at n * 0x10, word index = offset / 4
   localparam logic [APB_ADDR_W-1:0] OFS_TIMER_FIRST = 12'h000;
   localparam logic [APB_ADDR_W-1:0] OFS_TIMER_LAST = 12'h03c;
   localparam logic [APB_ADDR_W-1:0] OFS_SYNC_FLAGS = 12'h040;
   localparam int IDX_LSB = 2;
   // kind of register inside one timer block, equal to word index within it
   localparam logic [1:0] KIND_CTRL = 2'h0;
   localparam logic [1:0] KIND_PRESCALE = 2'h1;
   localparam logic [1:0] KIND_PERIOD = 2'h2;
   localparam logic [1:0] KIND_DUTY = 2'h3;
   // duty value is a 12-bit count
   localparam int DUTY_W = 12;
   localparam logic [DATA_W-1:0] DUTY_MASK = 32'h00000fff;
   localparam logic [DATA_W-1:0] FULL_MASK = 32'hffffffff;
   // status word: each timer owns one nibble at stride 8 bits
   localparam int STS_TIMER_STRIDE = 8;
   localparam logic [DATA_W-1:0] STS_USED_MASK = 32'h0f0f0f0f;
   localparam logic [DATA_W-1:0] STS_RESET = 32'h00000000;
   localparam logic [NUM_REGS-1:0] PEND_RESET = 16'h0000;
   localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h00000000;
endpackage

/* inc/reg_store_if.sv */
// carrier between the sync status logic and the timer register store
`timescale 1ns/100ps
`default_nettype none
interface reg_store_if;
   import pwm_sync_pkg::*;
   logic wrEn;
   logic [IDX_W-1:0] wrIdx;
   logic [DATA_W-1:0] wrData;
   logic [IDX_W-1:0] busIdx;
   logic [DATA_W-1:0] busData;
   logic [IDX_W-1:0] xferIdx;
   logic [DATA_W-1:0] xferData;
   modport ctrl (output wrEn, wrIdx, wrData, busIdx, xferIdx, input busData, xferData);
   modport mem (input wrEn, wrIdx, wrData, busIdx, xferIdx, output busData, xferData);
endinterface
`default_nettype wire

/* hdl/timer_reg_store.sv */
// sixteen timer value registers with one write and two registered read ports
`timescale 1ns/100ps
`default_nettype none
module timer_reg_store #(
   parameter int DEPTH = pwm_sync_pkg::NUM_REGS
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // access from the sync status logic
   reg_store_if.mem st
);
   import pwm_sync_pkg::*;

   logic [DATA_W-1:0] memQ [DEPTH];
   logic [DATA_W-1:0] memD [DEPTH];
   logic [DATA_W-1:0] busDataD;
   logic [DATA_W-1:0] xferDataD;
   logic [DATA_W-1:0] busDataQ;
   logic [DATA_W-1:0] xferDataQ;

   // next contents and read data; a read in the write cycle sees the old word
   always_comb begin
      for (int i = 0; i < DEPTH; i++) begin
         memD[i] = (st.wrEn && st.wrIdx == IDX_W'(i)) ? st.wrData : memQ[i];
      end
      busDataD = memQ[st.busIdx];
      xferDataD = memQ[st.xferIdx];
   end

   // storage and output registers
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            memQ[i] <= RDATA_ZERO;
         end
         busDataQ <= RDATA_ZERO;
         xferDataQ <= RDATA_ZERO;
      end else begin
         memQ <= memD;
         busDataQ <= busDataD;
         xferDataQ <= xferDataD;
      end
   end

   assign st.busData = busDataQ;
   assign st.xferData = xferDataQ;
endmodule
`default_nettype wire

/* test/pwm_write_sync_status_tb.sv */
// self-checking bench for the timer write sync status block
`timescale 1ns/100ps
`default_nettype none
module pwm_write_sync_status_tb;
   import pwm_sync_pkg::*;
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [APB_ADDR_W-1:0] paddr = 12'h000;
   logic [DATA_W-1:0] pwdata = 32'h00000000;
   logic [DATA_W-1:0] prdata;
   logic pready;
   logic pslverr;
   logic pwmTick = 1'b0;
   logic loadStrobe;
   logic [1:0] loadTimer;
   logic [1:0] loadKind;
   logic [DATA_W-1:0] loadData;
   int errors = 0;
   int tests_run = 0;
   logic [DATA_W-1:0] rd;
   logic err;
   logic [DATA_W-1:0] pend;

   pwm_write_sync_status pwm_write_sync_status_inst (
      .ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pwmTick(pwmTick),
      .loadStrobe(loadStrobe), .loadTimer(loadTimer), .loadKind(loadKind),
      .loadData(loadData)
   );

   // bench clock, 50 ns period
   always #25 ref_clk = ~ref_clk;

   // counts, verdict and end of run
   task automatic give_verdict();
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // compare one word
   task automatic check(input string name, input logic [DATA_W-1:0] exp,
         input logic [DATA_W-1:0] got);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s: expected %h seen %h", name, exp, got);
      end
   endtask

   // register address, written value and expected readback per index
   function automatic logic [APB_ADDR_W-1:0] addr_of(input int i);
      return 12'(i * 4);
   endfunction
   function automatic logic [DATA_W-1:0] wval(input int i);
      return 32'hc3a5f00f ^ (32'(i) << 8);
   endfunction
   function automatic logic [DATA_W-1:0] wexp(input int i);
      return (i % 4 == 3) ? (wval(i) & DUTY_MASK) : wval(i);
   endfunction
   function automatic int sbit(input int i);
      return (i / 4) * STS_TIMER_STRIDE + (i % 4);
   endfunction

   // one apb transfer: setup, access until pready, then release
   task automatic apb(input logic wr, input logic [APB_ADDR_W-1:0] addr,
         input logic [DATA_W-1:0] wdat, output logic [DATA_W-1:0] rdat, output logic serr);
      int n;
      logic rdy;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wdat;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      // answer read mid-cycle, settled for the edge that ends the access
      do begin
         @(negedge ref_clk);
         rdy = pready;
         rdat = prdata;
         serr = pslverr;
         @(posedge ref_clk);
         n++;
      end while (rdy !== 1'b1 && n < 20);
      if (rdy !== 1'b1) begin
         errors++;
         give_verdict();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // one load slot pulse, strobe expected two cycles later
   task automatic tick(input logic hit, input int i, input logic [DATA_W-1:0] dat);
      @(posedge ref_clk);
      pwmTick <= 1'b1;
      @(negedge ref_clk);
      check("strobe tick cycle", 32'h0, {31'h0, loadStrobe});
      @(posedge ref_clk);
      pwmTick <= 1'b0;
      @(negedge ref_clk);
      check("strobe next cycle", 32'h0, {31'h0, loadStrobe});
      @(posedge ref_clk);
      @(negedge ref_clk);
      check("strobe", {31'h0, hit}, {31'h0, loadStrobe});
      if (hit) begin
         check("load timer", 32'(i / 4), {30'h0, loadTimer});
         check("load kind", 32'(i % 4), {30'h0, loadKind});
         check("load data", dat, loadData);
      end
   endtask

   // watchdog against a hang
   initial begin
      repeat (5000) @(posedge ref_clk);
      errors++;
      give_verdict();
   end

   // flags read zero after reset
   task automatic test_reset_status();
      apb(1'b0, OFS_SYNC_FLAGS, 32'h0, rd, err);
      check("status after reset", STS_RESET, rd);
   endtask

   // each write raises its own flag and no other
   task automatic test_write_flags();
      pend = 32'h0;
      for (int i = 0; i < NUM_REGS; i++) begin
         apb(1'b1, addr_of(i), wval(i), rd, err);
         pend[sbit(i)] = 1'b1;
         apb(1'b0, OFS_SYNC_FLAGS, 32'h0, rd, err);
         check("status after write", pend, rd);
      end
   endtask

   // status word ignores writes, spare nibbles stay zero
   task automatic test_status_readonly();
      apb(1'b1, OFS_SYNC_FLAGS, FULL_MASK, rd, err);
      check("status write error", 32'h0, {31'h0, err});
      apb(1'b0, OFS_SYNC_FLAGS, 32'h0, rd, err);
      check("status after write", STS_USED_MASK, rd);
   endtask

   // address outside the map answers with an error and zero
   task automatic test_unmapped();
      apb(1'b0, 12'h044, 32'h0, rd, err);
      check("unmapped error", 32'h1, {31'h0, err});
      check("unmapped data", RDATA_ZERO, rd);
   endtask

   // stored words read back, duty cut to its count
   task automatic test_stored_values();
      for (int i = 0; i < NUM_REGS; i++) begin
         apb(1'b0, addr_of(i), 32'h0, rd, err);
         check("stored value", wexp(i), rd);
      end
   endtask

   // drain one register per slot, lowest index first
   task automatic test_drain();
      for (int i = 0; i < NUM_REGS; i++) begin
         tick(1'b1, i, wexp(i));
         pend[sbit(i)] = 1'b0;
         apb(1'b0, OFS_SYNC_FLAGS, 32'h0, rd, err);
         check("status after load", pend, rd);
      end
      tick(1'b0, 0, 32'h0);
   endtask

   // rewrite only once the flag has cleared
   task automatic test_rewrite();
      apb(1'b1, addr_of(11), 32'hfffffabc, rd, err);
      apb(1'b0, OFS_SYNC_FLAGS, 32'h0, rd, err);
      check("status rewrite", 32'h00080000, rd);
      tick(1'b1, 11, 32'h00000abc);
      apb(1'b0, OFS_SYNC_FLAGS, 32'h0, rd, err);
      check("status final", STS_RESET, rd);
   endtask

   // deliberate early rewrite landing between tick and strobe: old word
   // goes out, flag stays up, the new word follows on the next slot
   task automatic test_write_in_transfer();
      apb(1'b1, addr_of(5), wval(5), rd, err);
      fork
         tick(1'b1, 5, wval(5));
         apb(1'b1, addr_of(5), 32'h12345678, rd, err);
      join
      apb(1'b0, OFS_SYNC_FLAGS, 32'h0, rd, err);
      check("status after late write", 32'h00000200, rd);
      tick(1'b1, 5, 32'h12345678);
      apb(1'b0, OFS_SYNC_FLAGS, 32'h0, rd, err);
      check("status after second load", STS_RESET, rd);
   endtask

   // reset in mid-run drops a pending flag
   task automatic test_mid_reset();
      apb(1'b1, addr_of(6), wval(6), rd, err);
      apb(1'b0, OFS_SYNC_FLAGS, 32'h0, rd, err);
      check("status before reset", 32'h00000400, rd);
      @(posedge ref_clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      arst_n <= 1'b1;
      apb(1'b0, OFS_SYNC_FLAGS, 32'h0, rd, err);
      check("status after mid reset", STS_RESET, rd);
   endtask

   // main sequence
   initial begin
      repeat (6) @(posedge ref_clk);
      arst_n <= 1'b1;
      test_reset_status();
      test_write_flags();
      test_status_readonly();
      test_unmapped();
      test_stored_values();
      test_drain();
      test_rewrite();
      test_write_in_transfer();
      test_mid_reset();
      give_verdict();
   end
endmodule
`default_nettype wire
